// [video_switch_pkg.sv]
// constants shared by the video port switch control logic
package video_switch_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // clock-detect qualification window and settle time after a port change
  localparam int CDET_WINDOW_NS = 10000;
  localparam int CDET_WINDOW_CYC = (CDET_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CDET_MIN_EDGES = 8'h08;
  localparam logic [1:0] CDET_GOOD_WINDOWS = 2'h2;
  // link clock is divided before crossing so the slow side can sample it
  localparam logic [2:0] LINK_DIV_LAST = 3'h7;

  // two-wire target address; value is arbitrary, low bit set by address pin
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h2c;

  // register offsets
  localparam logic [7:0] STATUS_OFF = 8'h01;
  localparam logic [7:0] CTRL_OFF = 8'h02;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // status field positions
  localparam int ST_PWR_LSB = 0;
  localparam int ST_PORT_LSB = 4;
  localparam int ST_VALID_BIT = 6;

  // control field positions and reset value
  localparam int CT_EDGE_LSB = 0;
  localparam int CT_LEVEL_BIT = 2;
  localparam int CT_POWER_BIT = 3;
  localparam int CT_CDET_BIT = 4;
  localparam int CT_AUTO_BIT = 5;
  localparam int CT_PORT_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h18;

  localparam logic [1:0] EDGE_FASTEST = 2'h0;
  localparam int NUM_PORTS = 4;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [5:0] {
    TW_IDLE = 6'b00_0001,
    TW_ADDR = 6'b00_0010,
    TW_WRITE = 6'b00_0100,
    TW_ACK = 6'b00_1000,
    TW_READ = 6'b01_0000,
    TW_RACK = 6'b10_0000
  } tw_state_e;
endpackage : video_switch_pkg

// [video_port_switch_control.sv]
// switch control: port select, clock detect gating, hot-plug, two-wire target
// How it works
// - selected port gets clock terms, detector, repeater
// - data terms and outputs wait valid clock, except one cycle at a port change on the old port's clk_valid_q
// - unselected ports: all off but hot-plug
// - no valid clock: data terms off, outputs high-Z
// - select pin high register mode, low strapped
// - register mode interrupt on status changes
// - status register read drops interrupt
// - register mode sets edge, level, power, detect, port
// - strapped mode: select pins, low-power pin
// - strapped: fastest edge, level from pin
// - strapped interrupt mirrors selected clock valid
// - detect bypass only in register mode
// - four edge settings, default fastest
// - automatic selection only in register mode
// - hot-plug follows source power or sink
// - select pin decode, repeater to selected port
// - low-power pin low forces everything off
`timescale 1ns/10ps

module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [WIDTH-1:0] mem_q [DEPTH];
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = en_in && in_valid_in && !full;
  wire pop = en_in && out_ready_in && !empty;

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_q[rd_q[AW-1:0]];

  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          mem_q[e] <= '0;
        end else if (push && wr_q[AW-1:0] == AW'(e)) begin
          mem_q[e] <= in_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : sync_fifo

module video_port_switch_control (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic link_clk_in,
  input wire logic control_select_in,
  input wire logic source_select_low_in,
  input wire logic source_select_high_in,
  input wire logic power_save_n_in,
  input wire logic [video_switch_pkg::NUM_PORTS-1:0] source_power_detect_in,
  input wire logic sink_hotplug_in,
  input wire logic ddc_level_select_in,
  input wire logic local_addr_in,
  input wire logic local_scl_in,
  input wire logic local_sda_in,
  output logic local_sda_out,
  output logic local_sda_oe_out,
  output logic [video_switch_pkg::NUM_PORTS-1:0] clk_term_en_out,
  output logic [video_switch_pkg::NUM_PORTS-1:0] data_term_en_out,
  output logic [video_switch_pkg::NUM_PORTS-1:0] rx_en_out,
  output logic [video_switch_pkg::NUM_PORTS-1:0] ddc_repeat_en_out,
  output logic [video_switch_pkg::NUM_PORTS-1:0] port_hotplug_out,
  output logic [1:0] ddc_sink_port_out,
  output logic sink_link_en_out,
  output logic [1:0] edge_rate_out,
  output logic ddc_level_out,
  output logic irq_out
);
  import video_switch_pkg::*;

  // link domain: divided toggle, only thing that leaves this domain
  logic [2:0] link_div_q;
  logic link_tog_q;
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_div_q <= 3'h0;
      link_tog_q <= 1'b0;
    end else begin
      link_div_q <= link_div_q + 3'h1;
      if (link_div_q == LINK_DIV_LAST) link_tog_q <= !link_tog_q;
    end
  end

  // two-stage synchronisers for every pin and the link toggle
  localparam int NSYNC = 14;
  wire [NSYNC-1:0] raw = {link_tog_q, local_addr_in, local_sda_in, local_scl_in,
                          ddc_level_select_in, sink_hotplug_in, source_power_detect_in,
                          power_save_n_in, source_select_high_in, source_select_low_in,
                          control_select_in};
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  genvar b;
  generate
    for (b = 0; b < NSYNC; b++) begin : g_sync
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q[b] <= 1'b0;
          sync_q[b] <= 1'b0;
        end else if (clk_en_in) begin
          meta_q[b] <= raw[b];
          sync_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate

  wire reg_mode = sync_q[0];
  wire [1:0] pin_port = {sync_q[2], sync_q[1]};
  wire power_pin_n = sync_q[3];
  wire [NUM_PORTS-1:0] src_pwr = sync_q[7:4];
  wire sink_hp = sync_q[8];
  wire level_pin = sync_q[9];
  wire scl_s = sync_q[10];
  wire sda_s = sync_q[11];
  wire addr_pin = sync_q[12];
  wire tog_s = sync_q[13];

  // control register and effective configuration
  logic [7:0] ctrl_q;
  logic [1:0] auto_port;
  always_comb begin
    auto_port = 2'h0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (src_pwr[p]) auto_port = p[1:0];
    end
  end
  wire ctl_auto = reg_mode && ctrl_q[CT_AUTO_BIT];
  wire [1:0] reg_port = ctl_auto ? auto_port : ctrl_q[CT_PORT_LSB+:2];
  wire [1:0] sel_port = reg_mode ? reg_port : pin_port;
  wire powered = power_pin_n && (!reg_mode || ctrl_q[CT_POWER_BIT]);
  wire cdet_use = !reg_mode || ctrl_q[CT_CDET_BIT];
  wire [1:0] edge_eff = reg_mode ? ctrl_q[CT_EDGE_LSB+:2] : EDGE_FASTEST;
  wire level_eff = reg_mode ? ctrl_q[CT_LEVEL_BIT] : level_pin;

  // clock qualification: edges per window, two good windows to assert
  logic tog_prev_q;
  logic [7:0] win_cnt_q;
  logic [7:0] edge_cnt_q;
  logic [1:0] good_q;
  logic clk_valid_q;
  logic [1:0] sel_prev_q;
  wire tog_edge = tog_s != tog_prev_q;
  wire win_end = win_cnt_q == 8'(CDET_WINDOW_CYC - 1);
  wire win_good = edge_cnt_q >= CDET_MIN_EDGES;
  wire det_restart = !powered || (sel_port != sel_prev_q);
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_prev_q <= 1'b0;
      win_cnt_q <= 8'h00;
      edge_cnt_q <= 8'h00;
      good_q <= 2'h0;
      clk_valid_q <= 1'b0;
      sel_prev_q <= 2'h0;
    end else if (clk_en_in) begin
      tog_prev_q <= tog_s;
      sel_prev_q <= sel_port;
      if (det_restart) begin
        win_cnt_q <= 8'h00;
        edge_cnt_q <= 8'h00;
        good_q <= 2'h0;
        clk_valid_q <= 1'b0;
      end else if (win_end) begin
        win_cnt_q <= 8'h00;
        edge_cnt_q <= 8'h00;
        if (!win_good) begin
          good_q <= 2'h0;
          clk_valid_q <= 1'b0;
        end else if (good_q == CDET_GOOD_WINDOWS - 2'h1) begin
          clk_valid_q <= 1'b1;
        end else begin
          good_q <= good_q + 2'h1;
        end
      end else begin
        win_cnt_q <= win_cnt_q + 8'h01;
        if (tog_edge && edge_cnt_q != 8'hff) edge_cnt_q <= edge_cnt_q + 8'h01;
      end
    end
  end
  wire link_ok = cdet_use ? clk_valid_q : 1'b1;

  // per-port enables and hot-plug routing
  generate
    for (b = 0; b < NUM_PORTS; b++) begin : g_port
      wire is_sel = powered && (sel_port == 2'(b));
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          clk_term_en_out[b] <= 1'b0;
          rx_en_out[b] <= 1'b0;
          ddc_repeat_en_out[b] <= 1'b0;
          data_term_en_out[b] <= 1'b0;
          port_hotplug_out[b] <= 1'b0;
        end else if (clk_en_in) begin
          clk_term_en_out[b] <= is_sel;
          rx_en_out[b] <= is_sel;
          ddc_repeat_en_out[b] <= is_sel;
          data_term_en_out[b] <= is_sel && link_ok;
          port_hotplug_out[b] <= powered && (is_sel ? sink_hp : src_pwr[b]);
        end
      end
    end
  endgenerate

  // status change detection for the interrupt
  wire [7:0] status_now = {1'b0, link_ok, sel_port, src_pwr};
  logic [7:0] status_prev_q;
  logic irq_pend_q;
  logic status_read;
  wire status_change = reg_mode && powered && (status_now != status_prev_q);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_prev_q <= 8'h00;
      irq_pend_q <= 1'b0;
      sink_link_en_out <= 1'b0;
      ddc_sink_port_out <= 2'h0;
      edge_rate_out <= EDGE_FASTEST;
      ddc_level_out <= 1'b0;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      status_prev_q <= status_now;
      if (status_change) irq_pend_q <= 1'b1;
      else if (status_read || !reg_mode) irq_pend_q <= 1'b0;
      sink_link_en_out <= powered && link_ok;
      ddc_sink_port_out <= sel_port;
      edge_rate_out <= edge_eff;
      ddc_level_out <= level_eff;
      if (!powered) irq_out <= 1'b0;
      else if (reg_mode) irq_out <= irq_pend_q || status_change;
      else irq_out <= clk_valid_q;
    end
  end

  // two-wire target; it never drives clock or starts a transfer
  tw_state_e state_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic full_q;
  logic rw_q;
  logic have_ptr_q;
  logic [7:0] ptr_q;
  logic acked_q;
  logic sda_drive_q;
  logic master_ack_q;

  wire scl_rise = scl_s && !scl_prev_q;
  wire scl_fall = !scl_s && scl_prev_q;
  wire start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  wire stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  wire addr_match = shift_q[7:1] == {TARGET_ADDR_BASE[6:1], addr_pin};
  wire [7:0] read_byte = (ptr_q == STATUS_OFF) ? status_now :
                         (ptr_q == CTRL_OFF) ? ctrl_q : UNMAPPED_READ;
  wire fifo_ready;
  wire wr_push = (state_q == TW_WRITE) && scl_fall && full_q && have_ptr_q;
  wire load_read = scl_fall && ((state_q == TW_ACK && rw_q && acked_q) ||
                                (state_q == TW_RACK && master_ack_q));
  assign status_read = load_read && (ptr_q == STATUS_OFF);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= TW_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      full_q <= 1'b0;
      rw_q <= 1'b0;
      have_ptr_q <= 1'b0;
      ptr_q <= 8'h00;
      acked_q <= 1'b0;
      sda_drive_q <= 1'b0;
      master_ack_q <= 1'b0;
    end else if (clk_en_in) begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      if (!reg_mode || !powered || stop_cond) begin
        state_q <= TW_IDLE;
        sda_drive_q <= 1'b0;
      end else if (start_cond) begin
        state_q <= TW_ADDR;
        bit_q <= 3'h0;
        full_q <= 1'b0;
        have_ptr_q <= 1'b0;
        sda_drive_q <= 1'b0;
      end else begin
        case (state_q)
          TW_IDLE: sda_drive_q <= 1'b0;
          TW_ADDR, TW_WRITE: begin
            if (scl_rise && !full_q) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q <= bit_q + 3'h1;
              full_q <= bit_q == 3'h7;
            end else if (scl_fall && full_q) begin
              full_q <= 1'b0;
              state_q <= TW_ACK;
              if (state_q == TW_ADDR) begin
                rw_q <= shift_q[0];
                acked_q <= addr_match;
                sda_drive_q <= addr_match;
              end else if (!have_ptr_q) begin
                ptr_q <= shift_q;
                have_ptr_q <= 1'b1;
                acked_q <= 1'b1;
                sda_drive_q <= 1'b1;
              end else begin
                // full buffer refuses the byte with a not-acknowledge
                acked_q <= fifo_ready;
                sda_drive_q <= fifo_ready;
                if (fifo_ready) ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          TW_ACK: begin
            if (scl_fall) begin
              bit_q <= 3'h0;
              if (!acked_q) begin
                sda_drive_q <= 1'b0;
                state_q <= TW_IDLE;
              end else if (rw_q) begin
                shift_q <= {read_byte[6:0], 1'b0};
                sda_drive_q <= !read_byte[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= TW_READ;
              end else begin
                sda_drive_q <= 1'b0;
                state_q <= TW_WRITE;
              end
            end
          end
          TW_READ: begin
            if (scl_fall) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                sda_drive_q <= 1'b0;
                state_q <= TW_RACK;
              end else begin
                sda_drive_q <= !shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
              end
            end
          end
          TW_RACK: begin
            if (scl_rise) begin
              master_ack_q <= !sda_s;
            end else if (scl_fall) begin
              bit_q <= 3'h0;
              if (master_ack_q) begin
                shift_q <= {read_byte[6:0], 1'b0};
                sda_drive_q <= !read_byte[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= TW_READ;
              end else begin
                state_q <= TW_IDLE;
              end
            end
          end
          default: state_q <= TW_IDLE;
        endcase
      end
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      local_sda_out <= 1'b0;
      local_sda_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      local_sda_out <= 1'b0;
      local_sda_oe_out <= sda_drive_q;
    end
  end

  // register writes queue here; draining pauses while a port change settles
  wire fifo_valid;
  wire [FIFO_WIDTH-1:0] fifo_data;
  logic [7:0] settle_q;
  wire apply_ready = settle_q == 8'h00;
  wire apply = fifo_valid && apply_ready;
  wire ctrl_hit = fifo_data[15:8] == CTRL_OFF;
  wire port_moves = fifo_data[CT_PORT_LSB+1:CT_PORT_LSB] != ctrl_q[CT_PORT_LSB+:2];

  sync_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .en_in(clk_en_in),
    .in_valid_in(wr_push),
    .in_ready_out(fifo_ready),
    .in_data_in({ptr_q, shift_q}),
    .out_valid_out(fifo_valid),
    .out_ready_in(apply_ready),
    .out_data_out(fifo_data)
  );

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RESET;
      settle_q <= 8'h00;
    end else if (clk_en_in) begin
      if (apply && ctrl_hit) begin
        ctrl_q <= fifo_data[7:0];
        if (port_moves) settle_q <= 8'(SETTLE_CYC);
      end else if (settle_q != 8'h00) begin
        settle_q <= settle_q - 8'h01;
      end
    end
  end
endmodule : video_port_switch_control

// [video_switch_checker.sv]
// assertion checker for the switch control ports
`timescale 1ns/10ps
module video_switch_checker (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic control_select_in,
  input wire logic source_select_low_in,
  input wire logic source_select_high_in,
  input wire logic power_save_n_in,
  input wire logic [3:0] source_power_detect_in,
  input wire logic sink_hotplug_in,
  input wire logic ddc_level_select_in,
  input wire logic local_sda_out,
  input wire logic local_sda_oe_out,
  input wire logic [3:0] clk_term_en_out,
  input wire logic [3:0] data_term_en_out,
  input wire logic [3:0] rx_en_out,
  input wire logic [3:0] ddc_repeat_en_out,
  input wire logic [3:0] port_hotplug_out,
  input wire logic [1:0] ddc_sink_port_out,
  input wire logic sink_link_en_out,
  input wire logic [1:0] edge_rate_out,
  input wire logic ddc_level_out,
  input wire logic irq_out
);
  import video_switch_pkg::*;
  logic [3:0] hp_exp;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  always_comb begin
    hp_exp = source_power_detect_in;
    hp_exp[ddc_sink_port_out] = sink_hotplug_in;
  end
  // pins cross two sync stages and an output flop, so wait five quiet cycles
  sequence strap_calm;
    (!control_select_in && power_save_n_in &&
      $stable({source_select_high_in, source_select_low_in, ddc_level_select_in}))[*5];
  endsequence
  sequence pins_calm;
    (power_save_n_in && $stable({source_power_detect_in, sink_hotplug_in}))[*5];
  endsequence
  sequence lp_held;
    (!power_save_n_in)[*4];
  endsequence
  sel_onehot_a: assert property ($onehot0(clk_term_en_out))
    else $error("more than one port enabled");
  sel_enables_a: assert property (rx_en_out == clk_term_en_out && ddc_repeat_en_out == clk_term_en_out)
    else $error("receiver or repeater differs from selected port");
  data_gate_a: assert property (|data_term_en_out |-> sink_link_en_out && data_term_en_out == clk_term_en_out)
    else $error("data terminations on without link or selection");
  link_off_a: assert property (!sink_link_en_out |-> data_term_en_out == 4'h0)
    else $error("data terminations on while link invalid");
  low_power_a: assert property (lp_held |-> clk_term_en_out == 4'h0 && port_hotplug_out == 4'h0 && !sink_link_en_out && !irq_out)
    else $error("outputs active in low power");
  hotplug_route_a: assert property (pins_calm |-> port_hotplug_out == hp_exp)
    else $error("hot-plug routing wrong");
  strap_decode_a: assert property (strap_calm |-> ddc_sink_port_out == {source_select_high_in, source_select_low_in} && clk_term_en_out == (4'h1 << ddc_sink_port_out))
    else $error("strapped port decode wrong");
  strap_fixed_a: assert property (strap_calm |-> edge_rate_out == EDGE_FASTEST && ddc_level_out == ddc_level_select_in)
    else $error("strapped edge or level wrong");
  strap_irq_a: assert property (strap_calm ##0 $stable(sink_link_en_out)[*3] |-> irq_out == sink_link_en_out)
    else $error("strapped interrupt not following clock valid");
  sda_open_a: assert property (local_sda_oe_out |-> !local_sda_out)
    else $error("data line driven high");
  strap_quiet_a: assert property ((!control_select_in)[*5] |-> !local_sda_oe_out)
    else $error("two-wire answer in strapped mode");
endmodule : video_switch_checker

// [video_far_side_model.sv]
// far side: source link clock and the pulled-up two-wire data line
`timescale 1ns/10ps
module video_far_side_model (
  input wire logic run_in,
  input wire logic master_sda_in,
  input wire logic target_sda_in,
  input wire logic target_oe_in,
  output logic link_clk_out,
  output logic sda_line_out
);
  // clock stands still low while the source sends no stream
  initial begin
    link_clk_out = 1'b0;
    #13;
    forever begin
      #32;
      link_clk_out = run_in ? ~link_clk_out : 1'b0;
    end
  end
  // pull-up wire: any party pulls low, nobody drives high
  assign sda_line_out = master_sda_in & ~(target_oe_in & ~target_sda_in);
endmodule : video_far_side_model

// [video_port_switch_control_tb_top.sv]
// self-checking bench for the video port switch control
`timescale 1ns/10ps
module video_port_switch_control_tb_top;
  import video_switch_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic [3:0] pwr;
    logic hp;
    logic lvl;
    logic [3:0] term;
    logic [3:0] hpo;
  } row_s;
  localparam logic [7:0] WR_ADDR = {TARGET_ADDR_BASE[6:1], 2'b10};
  localparam logic [7:0] RD_ADDR = {TARGET_ADDR_BASE[6:1], 2'b11};
  row_s rows [4] = '{'{2'h0, 4'hf, 1'b0, 1'b0, 4'h1, 4'he}, '{2'h1, 4'h5, 1'b1, 1'b1, 4'h2, 4'h7},
    '{2'h2, 4'h0, 1'b1, 1'b0, 4'h4, 4'h4}, '{2'h3, 4'ha, 1'b0, 1'b1, 4'h8, 4'h2}};
  logic ref_clk_in, rst_n_in, control_select_in, source_select_low_in, source_select_high_in;
  logic power_save_n_in, sink_hotplug_in, ddc_level_select_in, local_scl_in, master_sda;
  logic run_link, link_clk, sda_line, local_sda_out, local_sda_oe_out, sink_link_en_out;
  logic ddc_level_out, irq_out;
  logic [3:0] source_power_detect_in, clk_term_en_out, data_term_en_out, rx_en_out;
  logic [3:0] ddc_repeat_en_out, port_hotplug_out;
  logic [1:0] ddc_sink_port_out, edge_rate_out;
  logic [7:0] rd;
  int fails, n_checks;

  video_port_switch_control i_video_port_switch_control (
    .ref_clk_in, .rst_n_in, .clk_en_in(1'b1), .link_clk_in(link_clk), .control_select_in,
    .source_select_low_in, .source_select_high_in, .power_save_n_in, .source_power_detect_in,
    .sink_hotplug_in, .ddc_level_select_in, .local_addr_in(1'b1), .local_scl_in,
    .local_sda_in(sda_line), .local_sda_out, .local_sda_oe_out, .clk_term_en_out,
    .data_term_en_out, .rx_en_out, .ddc_repeat_en_out, .port_hotplug_out, .ddc_sink_port_out,
    .sink_link_en_out, .edge_rate_out, .ddc_level_out, .irq_out);
  video_far_side_model i_video_far_side_model (.run_in(run_link), .master_sda_in(master_sda),
    .target_sda_in(local_sda_out), .target_oe_in(local_sda_oe_out), .link_clk_out(link_clk),
    .sda_line_out(sda_line));

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #5;
  endtask : tick
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // data only moves while the clock is low, so no false start or stop
  task automatic tw_bit(input logic b, output logic r);
    tick(4);
    master_sda = b;
    tick(4);
    local_scl_in = 1'b1;
    tick(8);
    r = sda_line;
    local_scl_in = 1'b0;
  endtask : tw_bit
  task automatic tw_edge(input logic first);
    tick(4);
    master_sda = first;
    tick(4);
    local_scl_in = 1'b1;
    tick(8);
    master_sda = ~first;
    tick(8);
    // start leaves the clock low for the first bit, stop leaves it idle high
    local_scl_in = ~first;
  endtask : tw_edge
  task automatic tw_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) tw_bit(d[i], q[i]);
    tw_bit(1'b1, a);
    ack = ~a;
  endtask : tw_byte
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] data);
    logic [7:0] q;
    logic a;
    tw_edge(1'b1);
    tw_byte(WR_ADDR, q, a);
    chk("addr ack", 8'h01, {7'h0, a});
    tw_byte(ptr, q, a);
    chk("ptr ack", 8'h01, {7'h0, a});
    tw_byte(data, q, a);
    chk("data ack", 8'h01, {7'h0, a});
    tw_edge(1'b0);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] q);
    logic a;
    tw_edge(1'b1);
    tw_byte(WR_ADDR, q, a);
    tw_byte(ptr, q, a);
    tw_edge(1'b1);
    tw_byte(RD_ADDR, q, a);
    chk("read ack", 8'h01, {7'h0, a});
    tw_byte(8'hff, q, a);
    tw_edge(1'b0);
  endtask : reg_rd
  task automatic wait_link(input logic lvl);
    int i;
    i = 0;
    while (sink_link_en_out !== lvl && i < 600) begin
      tick(1);
      i++;
    end
    if (sink_link_en_out !== lvl) begin
      chk("link wait", {7'h0, lvl}, {7'h0, sink_link_en_out});
      results();
    end
  endtask : wait_link

  initial begin
    fails = 0;
    n_checks = 0;
    rst_n_in = 1'b0;
    control_select_in = 1'b0;
    {source_select_high_in, source_select_low_in} = 2'h0;
    power_save_n_in = 1'b1;
    source_power_detect_in = 4'h0;
    sink_hotplug_in = 1'b0;
    ddc_level_select_in = 1'b0;
    local_scl_in = 1'b1;
    master_sda = 1'b1;
    run_link = 1'b0;
    tick(16);
    chk("reset outs", 8'h00, {clk_term_en_out, edge_rate_out, irq_out, sink_link_en_out});
    rst_n_in = 1'b1;
    tick(6);
    foreach (rows[k]) begin
      {source_select_high_in, source_select_low_in} = rows[k].sel;
      source_power_detect_in = rows[k].pwr;
      sink_hotplug_in = rows[k].hp;
      ddc_level_select_in = rows[k].lvl;
      tick(6);
      chk("clk_term", {4'h0, rows[k].term}, {4'h0, clk_term_en_out});
      chk("rx_en", {4'h0, rows[k].term}, {4'h0, rx_en_out});
      chk("repeater", {4'h0, rows[k].term}, {4'h0, ddc_repeat_en_out});
      chk("data_term", 8'h00, {4'h0, data_term_en_out});
      chk("hotplug", {4'h0, rows[k].hpo}, {4'h0, port_hotplug_out});
      chk("ddc_port", {6'h0, rows[k].sel}, {6'h0, ddc_sink_port_out});
      chk("edge_lvl", {5'h0, EDGE_FASTEST, rows[k].lvl}, {5'h0, edge_rate_out, ddc_level_out});
    end
    run_link = 1'b1;
    wait_link(1'b1);
    chk("data_term", 8'h08, {4'h0, data_term_en_out});
    chk("irq", 8'h01, {7'h0, irq_out});
    run_link = 1'b0;
    wait_link(1'b0);
    chk("data_term", 8'h00, {4'h0, data_term_en_out});
    chk("irq", 8'h00, {7'h0, irq_out});
    control_select_in = 1'b1;
    tick(10);
    reg_rd(CTRL_OFF, rd);
    chk("ctrl reset", CTRL_RESET, rd);
    reg_rd(STATUS_OFF, rd);
    tick(5);
    chk("irq", 8'h00, {7'h0, irq_out});
    source_power_detect_in = 4'h3;
    tick(6);
    chk("irq", 8'h01, {7'h0, irq_out});
    reg_rd(STATUS_OFF, rd);
    chk("status", 8'h03, rd);
    tick(5);
    chk("irq", 8'h00, {7'h0, irq_out});
    reg_wr(CTRL_OFF, 8'h9b);
    tick(30);
    chk("ddc_port", 8'h02, {6'h0, ddc_sink_port_out});
    chk("clk_term", 8'h04, {4'h0, clk_term_en_out});
    for (int e = 0; e < 4; e++) begin
      reg_wr(CTRL_OFF, {6'h26, e[1:0]});
      tick(5);
      chk("edge", {6'h0, e[1:0]}, {6'h0, edge_rate_out});
    end
    reg_rd(CTRL_OFF, rd);
    chk("ctrl back", 8'h9b, rd);
    reg_rd(8'h05, rd);
    chk("unmapped", UNMAPPED_READ, rd);
    reg_wr(CTRL_OFF, 8'h88);
    wait_link(1'b1);
    chk("bypass", 8'h04, {4'h0, data_term_en_out});
    source_power_detect_in = 4'h6;
    reg_wr(CTRL_OFF, 8'h38);
    tick(30);
    chk("auto port", 8'h01, {6'h0, ddc_sink_port_out});
    control_select_in = 1'b0;
    {source_select_high_in, source_select_low_in} = 2'h0;
    tick(8);
    chk("strap port", 8'h00, {6'h0, ddc_sink_port_out});
    wait_link(1'b0);
    chk("no bypass", 8'h00, {4'h0, data_term_en_out});
    power_save_n_in = 1'b0;
    tick(6);
    chk("low power", 8'h00, {clk_term_en_out, port_hotplug_out});
    chk("lp irq", 8'h00, {7'h0, irq_out});
    results();
  end
endmodule : video_port_switch_control_tb_top

bind video_port_switch_control video_switch_checker i_video_switch_checker (.*);
